/* shared/irqmx_params.svh */
// Register offsets, field positions, reset values and sizes of the interrupt pin router
`ifndef IRQMX_PARAMS_SVH
`define IRQMX_PARAMS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define IRQMX_SEL_IDX        10'h00d
`define IRQMX_CTRL_IDX       10'h020

// ==========================================================================
// Source select register fields
`define IRQMX_RX_A_HI        7
`define IRQMX_RX_A_LO        6
`define IRQMX_RX_B_HI        5
`define IRQMX_RX_B_LO        4
`define IRQMX_TX_B_BIT       3
`define IRQMX_FULL_BIT       2
`define IRQMX_NEMPTY_BIT     1
`define IRQMX_OVR_BIT        0
`define IRQMX_SEL_RST        8'h00

// ==========================================================================
// Mode control register fields
`define IRQMX_BUF_BIT        0
`define IRQMX_PKT_BIT        1
`define IRQMX_MATCH_BIT      2
`define IRQMX_SFULL_BIT      3
`define IRQMX_SIZE_HI        5
`define IRQMX_SIZE_LO        4
`define IRQMX_THR_HI         13
`define IRQMX_THR_LO         8
`define IRQMX_THR_RST        6'h0f

// ==========================================================================
// Queue geometry
`define IRQMX_DEPTH_UNIT     7'h10

`endif

/* shared/irqmx_pkg.sv */
// Types shared by the interrupt pin router modules
package irqmx_pkg;

    typedef enum logic [1:0] {IRQMX_CONT, IRQMX_BUF, IRQMX_PKT} irqmx_mode_t;

    typedef struct packed {
        logic [1:0]  rx_a_sel;
        logic [1:0]  rx_b_sel;
        logic        tx_b_sel;
        logic        overrun;
        logic        buffered;
        logic        packet_en;
        logic        node_match_enable;
        logic        start_full;
        logic [1:0]  size;
        logic [5:0]  thresh;
        logic        pin_a;
        logic        pin_b;
        logic        flush;
        logic [31:0] rdata;
    } irqmx_state_t;

endpackage : irqmx_pkg

/* shared/irqmx_level_if.sv */
// Queue level compare signals between the router and its level comparator
`timescale 1ns/1ps
interface irqmx_level_if;
    logic [6:0] level;
    logic [1:0] size;
    logic [5:0] thresh;
    logic       full;
    logic       not_empty;
    logic       at_thresh;

    modport cmp  (input level, size, thresh, output full, not_empty, at_thresh);
    modport user (output level, size, thresh, input full, not_empty, at_thresh);
endinterface : irqmx_level_if

/* rtl/irqmx_sync.sv */
// Two flip-flop synchroniser for signals from another clock domain
`timescale 1ns/1ps
module irqmx_sync
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stage1 <= '0;
            q      <= '0;
        end
        else
        begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule : irqmx_sync

/* rtl/irqmx_level.sv */
// Queue occupancy comparator: full, not empty and threshold reached
`timescale 1ns/1ps
`include "irqmx_params.svh"
module irqmx_level
(
    // Level and results
    irqmx_level_if.cmp lvl
);
    logic [6:0] depth;

    // Depth is 16, 32, 48 or 64 bytes
    assign depth         = 7'((lvl.size + 2'h1) * `IRQMX_DEPTH_UNIT);
    assign lvl.full      = (lvl.level >= depth);
    assign lvl.not_empty = (lvl.level != 7'h00);
    assign lvl.at_thresh = (lvl.level >= 7'({1'b0, lvl.thresh} + 7'h01));
endmodule : irqmx_level

/* rtl/irqmx_top.sv */
// Interrupt pin source router with APB register access
`timescale 1ns/1ps
`include "irqmx_params.svh"
// Summary of operation
// - Continuous receive: pin A shows start-pattern detect whatever its selector holds.
// - Buffered receive pin A: 00 low, 01 byte strobe, 10 not-empty, 11 start detect.
// - Packet receive pin A: 00 payload ready, 01 byte strobe, 10 not-empty.
// - Packet receive pin A selector 11: address match if enabled, else start detect.
// - Continuous receive: pin B shows the recovered bit clock for any selector.
// - Buffered receive pin B: 00 low, 01 full, 10 signal strength, 11 level.
// - Packet receive pin B: 00 check pass, 01 full, 10 signal strength, 11 level.
// - Continuous transmit: pin B bit clock, pin A low, transmit selector ignored.
// - Buffered or packet transmit: pin B full when 0, last bit sent when 1.
// - Transmit pin A: buffered not-empty; packet level if policy 0, else not-empty.
// - Status bit 2 reads queue full, also an interrupt source.
// - Status bit 1 reads low when queue empty, high otherwise.
// - Bit 0 flags overrun; writing one clears it and flushes the queue.
// - Source select register resets to all zeros.
// - Mode bit picks continuous or buffered; packet enable overrides both.
// - Level interrupts assert at threshold plus one bytes; threshold resets to 15.
// - Queue size is 16, 32, 48 or 64 bytes by a two-bit field.
module irqmx_top
    import irqmx_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Radio state
    input  wire logic        rx_active,
    input  wire logic        in_standby,
    // Event sources
    input  wire logic        start_detect,
    input  wire logic        byte_written,
    input  wire logic        payload_ready,
    input  wire logic        address_match,
    input  wire logic        check_pass,
    input  wire logic        signal_strength_irq,
    input  wire logic        tx_last_bit,
    input  wire logic        recovered_bit_clock,
    // Data queue
    input  wire logic [6:0]  queue_level,
    input  wire logic        queue_overrun_event,
    output logic             queue_flush,
    // Interrupt pins
    output logic             irq_pin_a,
    output logic             irq_pin_b
);
    // ==========================================================================
    // State, decode and helpers
    irqmx_state_t state;
    irqmx_state_t next_state;
    irqmx_mode_t  mode;
    logic         bit_clock_s;
    logic         hit_sel;
    logic         hit_ctrl;
    logic         wr_access;
    logic         rd_setup;
    logic         full;
    logic         not_empty;
    logic         at_thresh;
    logic [31:0]  rd_value;

    irqmx_level_if lvl ();

    // The bit clock comes from the demodulator's own timing, so it is resynchronised
    irqmx_sync #(.WIDTH(1)) u_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (recovered_bit_clock),
        .q       (bit_clock_s)
    );

    irqmx_level u_level
    (
        .lvl (lvl.cmp)
    );

    assign lvl.level  = queue_level;
    assign lvl.size   = state.size;
    assign lvl.thresh = state.thresh;
    assign full       = lvl.full;
    assign not_empty  = lvl.not_empty;
    assign at_thresh  = lvl.at_thresh;

    // ==========================================================================
    // APB decode; zero wait states
    assign hit_sel   = (paddr[11:2] == `IRQMX_SEL_IDX);
    assign hit_ctrl  = (paddr[11:2] == `IRQMX_CTRL_IDX);
    assign wr_access = psel && penable && pwrite;
    assign rd_setup  = psel && !penable && !pwrite;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !(hit_sel || hit_ctrl);
    assign prdata    = state.rdata;

    // Packet enable overrides the buffered/continuous choice
    assign mode = state.packet_en ? IRQMX_PKT :
                  (state.buffered ? IRQMX_BUF : IRQMX_CONT);

    always_comb
    begin
        rd_value = 32'h0000_0000;
        if (hit_sel)
        begin
            rd_value[7:3]                = {state.rx_a_sel, state.rx_b_sel, state.tx_b_sel};
            rd_value[`IRQMX_FULL_BIT]   = full;
            rd_value[`IRQMX_NEMPTY_BIT] = not_empty;
            rd_value[`IRQMX_OVR_BIT]    = state.overrun;
        end
        else if (hit_ctrl)
        begin
            rd_value[`IRQMX_BUF_BIT]                 = state.buffered;
            rd_value[`IRQMX_PKT_BIT]                 = state.packet_en;
            rd_value[`IRQMX_MATCH_BIT]               = state.node_match_enable;
            rd_value[`IRQMX_SFULL_BIT]               = state.start_full;
            rd_value[`IRQMX_SIZE_HI:`IRQMX_SIZE_LO] = state.size;
            rd_value[`IRQMX_THR_HI:`IRQMX_THR_LO]   = state.thresh;
        end
    end

    // ==========================================================================
    // Next state
    always_comb
    begin
        next_state       = state;
        next_state.flush = 1'b0;
        // Read data is captured in the setup cycle so it comes from a flop in the access cycle
        if (rd_setup)
            next_state.rdata = rd_value;
        if (wr_access && hit_sel && pstrb[0])
        begin
            next_state.rx_a_sel = pwdata[`IRQMX_RX_A_HI:`IRQMX_RX_A_LO];
            next_state.rx_b_sel = pwdata[`IRQMX_RX_B_HI:`IRQMX_RX_B_LO];
            next_state.tx_b_sel = pwdata[`IRQMX_TX_B_BIT];
            if (pwdata[`IRQMX_OVR_BIT])
            begin
                next_state.overrun = 1'b0;
                next_state.flush   = 1'b1;
            end
        end
        if (wr_access && hit_ctrl && pstrb[0])
        begin
            next_state.buffered          = pwdata[`IRQMX_BUF_BIT];
            next_state.packet_en         = pwdata[`IRQMX_PKT_BIT];
            next_state.node_match_enable = pwdata[`IRQMX_MATCH_BIT];
            next_state.start_full        = pwdata[`IRQMX_SFULL_BIT];
            next_state.size              = pwdata[`IRQMX_SIZE_HI:`IRQMX_SIZE_LO];
        end
        if (wr_access && hit_ctrl && pstrb[1])
            next_state.thresh = pwdata[`IRQMX_THR_HI:`IRQMX_THR_LO];
        // A new overrun in the clearing cycle is kept
        if (queue_overrun_event)
            next_state.overrun = 1'b1;

        // Pin routing from the current selectors; the pins are flops
        next_state.pin_a = 1'b0;
        next_state.pin_b = 1'b0;
        if (in_standby)
        begin
            // Only the sources marked as live in standby reach the pins
            if (mode != IRQMX_CONT && state.rx_a_sel == 2'b10)
                next_state.pin_a = not_empty;
            if (mode != IRQMX_CONT && state.rx_b_sel == 2'b11)
                next_state.pin_b = at_thresh;
            else if (mode == IRQMX_PKT && state.rx_b_sel == 2'b01)
                next_state.pin_b = full;
        end
        else if (rx_active)
        begin
            unique case (mode)
                IRQMX_CONT:
                begin
                    next_state.pin_a = start_detect;
                    next_state.pin_b = bit_clock_s;
                end
                IRQMX_BUF:
                begin
                    unique case (state.rx_a_sel)
                        2'b00: next_state.pin_a = 1'b0;
                        2'b01: next_state.pin_a = byte_written;
                        2'b10: next_state.pin_a = not_empty;
                        2'b11: next_state.pin_a = start_detect;
                    endcase
                    unique case (state.rx_b_sel)
                        2'b00: next_state.pin_b = 1'b0;
                        2'b01: next_state.pin_b = full;
                        2'b10: next_state.pin_b = signal_strength_irq;
                        2'b11: next_state.pin_b = at_thresh;
                    endcase
                end
                IRQMX_PKT:
                begin
                    unique case (state.rx_a_sel)
                        2'b00: next_state.pin_a = payload_ready;
                        2'b01: next_state.pin_a = byte_written;
                        2'b10: next_state.pin_a = not_empty;
                        2'b11: next_state.pin_a = state.node_match_enable ?
                                                  address_match : start_detect;
                    endcase
                    unique case (state.rx_b_sel)
                        2'b00: next_state.pin_b = check_pass;
                        2'b01: next_state.pin_b = full;
                        2'b10: next_state.pin_b = signal_strength_irq;
                        2'b11: next_state.pin_b = at_thresh;
                    endcase
                end
                default:
                begin
                    next_state.pin_a = 1'b0;
                    next_state.pin_b = 1'b0;
                end
            endcase
        end
        else
        begin
            if (mode == IRQMX_CONT)
            begin
                next_state.pin_a = 1'b0;
                next_state.pin_b = bit_clock_s;
            end
            else
            begin
                next_state.pin_b = state.tx_b_sel ? tx_last_bit : full;
                if (mode == IRQMX_PKT && !state.start_full)
                    next_state.pin_a = at_thresh;
                else
                    next_state.pin_a = not_empty;
            end
        end
    end

    // ==========================================================================
    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state        <= '0;
            state.thresh <= `IRQMX_THR_RST;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign irq_pin_a   = state.pin_a;
    assign irq_pin_b   = state.pin_b;
    assign queue_flush = state.flush;

    // ==========================================================================
    // Assertions
    property p_cont_rx_a;
        @(posedge pclk) disable iff (!presetn)
        (rx_active && !in_standby && mode == IRQMX_CONT) |=> irq_pin_a == $past(start_detect);
    endproperty
    a_cont_rx_a: assert property (p_cont_rx_a) else $error("pin A not start detect");

    property p_buf_rx_a_low;
        @(posedge pclk) disable iff (!presetn)
        (rx_active && !in_standby && mode == IRQMX_BUF && state.rx_a_sel == 2'b00)
            |=> !irq_pin_a;
    endproperty
    a_buf_rx_a_low: assert property (p_buf_rx_a_low) else $error("pin A not low");

    property p_pkt_rx_a_ready;
        @(posedge pclk) disable iff (!presetn)
        (rx_active && !in_standby && mode == IRQMX_PKT && state.rx_a_sel == 2'b00)
            |=> irq_pin_a == $past(payload_ready);
    endproperty
    a_pkt_rx_a_ready: assert property (p_pkt_rx_a_ready) else $error("pin A not payload");

    property p_pkt_rx_a_match;
        @(posedge pclk) disable iff (!presetn)
        (rx_active && !in_standby && mode == IRQMX_PKT && state.rx_a_sel == 2'b11)
            |=> irq_pin_a == ($past(state.node_match_enable) ? $past(address_match)
                                                              : $past(start_detect));
    endproperty
    a_pkt_rx_a_match: assert property (p_pkt_rx_a_match) else $error("pin A match wrong");

    property p_cont_b_clock;
        @(posedge pclk) disable iff (!presetn)
        (!in_standby && mode == IRQMX_CONT) |=> irq_pin_b == $past(bit_clock_s);
    endproperty
    a_cont_b_clock: assert property (p_cont_b_clock) else $error("pin B not bit clock");

    property p_buf_rx_b_full;
        @(posedge pclk) disable iff (!presetn)
        (rx_active && !in_standby && mode == IRQMX_BUF && state.rx_b_sel == 2'b01)
            |=> irq_pin_b == $past(full);
    endproperty
    a_buf_rx_b_full: assert property (p_buf_rx_b_full) else $error("pin B not full");

    property p_pkt_rx_b_check;
        @(posedge pclk) disable iff (!presetn)
        (rx_active && !in_standby && mode == IRQMX_PKT && state.rx_b_sel == 2'b00)
            |=> irq_pin_b == $past(check_pass);
    endproperty
    a_pkt_rx_b_check: assert property (p_pkt_rx_b_check) else $error("pin B not check");

    property p_cont_tx_a;
        @(posedge pclk) disable iff (!presetn)
        (!rx_active && !in_standby && mode == IRQMX_CONT) |=> !irq_pin_a;
    endproperty
    a_cont_tx_a: assert property (p_cont_tx_a) else $error("pin A not low in tx");

    property p_tx_b_sel;
        @(posedge pclk) disable iff (!presetn)
        (!rx_active && !in_standby && mode != IRQMX_CONT)
            |=> irq_pin_b == ($past(state.tx_b_sel) ? $past(tx_last_bit) : $past(full));
    endproperty
    a_tx_b_sel: assert property (p_tx_b_sel) else $error("pin B tx route wrong");

    property p_tx_a_policy;
        @(posedge pclk) disable iff (!presetn)
        (!rx_active && !in_standby && mode == IRQMX_PKT && !state.start_full)
            |=> irq_pin_a == $past(at_thresh);
    endproperty
    a_tx_a_policy: assert property (p_tx_a_policy) else $error("pin A not level");

    property p_ovr_clear_flush;
        @(posedge pclk) disable iff (!presetn)
        (wr_access && hit_sel && pstrb[0] && pwdata[0] && !queue_overrun_event)
            |=> !state.overrun && queue_flush ##1 !queue_flush;
    endproperty
    a_ovr_clear_flush: assert property (p_ovr_clear_flush) else $error("clear failed");

    property p_ovr_keep;
        @(posedge pclk) disable iff (!presetn)
        (!(wr_access && hit_sel && pwdata[0]) && !queue_overrun_event)
            |=> state.overrun == $past(state.overrun) && !queue_flush;
    endproperty
    a_ovr_keep: assert property (p_ovr_keep) else $error("overrun changed");

    property p_sel_readback;
        @(posedge pclk) disable iff (!presetn)
        (wr_access && hit_sel && pstrb[0])
            |=> {state.rx_a_sel, state.rx_b_sel, state.tx_b_sel} == $past(pwdata[7:3]);
    endproperty
    a_sel_readback: assert property (p_sel_readback) else $error("selector not stored");
endmodule : irqmx_top

/* test/irqmx_queue_model.sv */
// Behavioural data queue that feeds the router its occupancy
`timescale 1ns/1ps
module irqmx_queue_model
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Fill control from the bench
    input  wire logic       fill_load,
    input  wire logic [6:0] fill_val,
    // Router side
    input  wire logic       queue_flush,
    output logic      [6:0] queue_level
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            queue_level <= 7'h00;
        else if (queue_flush)
            queue_level <= 7'h00;
        else if (fill_load)
            queue_level <= fill_val;
    end
endmodule : irqmx_queue_model

/* test/testbench.sv */
// Self-checking bench for the interrupt pin router
`timescale 1ns/1ps
`include "irqmx_params.svh"
module testbench;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er, rx = 0, ovr = 0, fld = 0, stb = 0, flush, pa, pb;
    logic [7:0]  src = 8'h00;
    logic [6:0]  fv = 7'h00, lvl;
    int          failures = 0, checks_done = 0;
    localparam logic [11:0] SEL = {`IRQMX_SEL_IDX, 2'b00};
    localparam logic [11:0] CTL = {`IRQMX_CTRL_IDX, 2'b00};
    always #5 pclk = ~pclk;
    irqmx_top u_irqmx_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_active(rx), .in_standby(stb),
        .start_detect(src[0]), .byte_written(src[1]), .payload_ready(src[2]),
        .address_match(src[3]), .check_pass(src[4]), .signal_strength_irq(src[5]),
        .tx_last_bit(src[6]), .recovered_bit_clock(src[7]), .queue_level(lvl),
        .queue_overrun_event(ovr), .queue_flush(flush), .irq_pin_a(pa), .irq_pin_b(pb));
    irqmx_queue_model u_irqmx_queue_model (.pclk(pclk), .presetn(presetn),
        .fill_load(fld), .fill_val(fv), .queue_flush(flush), .queue_level(lvl));
    // ==========================================================
    // Shared tasks
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 20)
        begin
            failures++;
            tally_and_finish();
        end
    endtask : apb
    task automatic loadq(input logic [6:0] v);
        @(posedge pclk);
        fld <= 1;
        fv <= v;
        @(posedge pclk);
        fld <= 0;
        repeat (2) @(posedge pclk);
    endtask : loadq
    // Program mode and selectors, present sources, then judge both pins
    task automatic rt(input logic [31:0] c, input logic r, input logic [7:0] s,
                      input logic [7:0] ev, input logic [6:0] q, input logic ea, eb);
        apb(1, CTL, c);
        apb(1, SEL, {24'h0, s});
        @(posedge pclk);
        rx <= r;
        src <= ev;
        loadq(q);
        repeat (4) @(posedge pclk);
        #1;
        chk("irq_pin_a", {31'h0, ea}, {31'h0, pa});
        chk("irq_pin_b", {31'h0, eb}, {31'h0, pb});
    endtask : rt
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        apb(0, SEL, 32'h0);
        chk("irq_source_select", 32'h00, rd);
        apb(0, CTL, 32'h0);
        chk("control reset", {18'h0, `IRQMX_THR_RST, 8'h00}, rd);
        apb(0, 12'hffc, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        $display("test reset done");
    endtask : t_reset
    task automatic t_cont;
        rt(32'h0300, 1, 8'hf0, 8'h81, 7'd0, 1, 1);
        rt(32'h0300, 1, 8'h50, 8'h7e, 7'd16, 0, 0);
        rt(32'h0300, 1, 8'h00, 8'h01, 7'd0, 1, 0);
        rt(32'h0300, 0, 8'hf8, 8'h80, 7'd0, 0, 1);
        rt(32'h0300, 0, 8'h00, 8'h7f, 7'd16, 0, 0);
        $display("test continuous done");
    endtask : t_cont
    task automatic t_buf_rx;
        rt(32'h0301, 1, 8'h00, 8'hff, 7'd16, 0, 0);
        rt(32'h0301, 1, 8'h50, 8'h02, 7'd16, 1, 1);
        rt(32'h0301, 1, 8'h50, 8'hfd, 7'd4, 0, 0);
        rt(32'h0301, 1, 8'ha0, 8'h00, 7'd1, 1, 0);
        rt(32'h0301, 1, 8'ha0, 8'h20, 7'd0, 0, 1);
        rt(32'h0301, 1, 8'hf0, 8'h01, 7'd4, 1, 1);
        rt(32'h0301, 1, 8'hf0, 8'hfe, 7'd3, 0, 0);
        rt(32'h0311, 1, 8'h10, 8'h00, 7'd31, 0, 0);
        rt(32'h0311, 1, 8'h10, 8'h00, 7'd32, 0, 1);
        rt(32'h0321, 1, 8'h10, 8'h00, 7'd47, 0, 0);
        rt(32'h0321, 1, 8'h10, 8'h00, 7'd48, 0, 1);
        rt(32'h0331, 1, 8'h10, 8'h00, 7'd63, 0, 0);
        rt(32'h0331, 1, 8'h10, 8'h00, 7'd64, 0, 1);
        $display("test buffered receive done");
    endtask : t_buf_rx
    task automatic t_pkt_rx;
        rt(32'h0302, 1, 8'h00, 8'h14, 7'd0, 1, 1);
        rt(32'h0302, 1, 8'h00, 8'heb, 7'd16, 0, 0);
        rt(32'h0302, 1, 8'h50, 8'h02, 7'd16, 1, 1);
        rt(32'h0302, 1, 8'h50, 8'hfd, 7'd4, 0, 0);
        rt(32'h0302, 1, 8'ha0, 8'h20, 7'd1, 1, 1);
        rt(32'h0302, 1, 8'ha0, 8'hdf, 7'd0, 0, 0);
        rt(32'h0302, 1, 8'hf0, 8'h01, 7'd4, 1, 1);
        rt(32'h0302, 1, 8'hf0, 8'hfe, 7'd1, 0, 0);
        rt(32'h0306, 1, 8'hf0, 8'h08, 7'd0, 1, 0);
        rt(32'h0306, 1, 8'hf0, 8'hf7, 7'd0, 0, 0);
        rt(32'h0303, 1, 8'h00, 8'h14, 7'd0, 1, 1);
        $display("test packet receive done");
    endtask : t_pkt_rx
    task automatic t_tx;
        rt(32'h0301, 0, 8'h00, 8'h00, 7'd16, 1, 1);
        rt(32'h0301, 0, 8'h00, 8'hff, 7'd0, 0, 0);
        rt(32'h0301, 0, 8'h08, 8'h40, 7'd1, 1, 1);
        rt(32'h0301, 0, 8'h08, 8'hbf, 7'd16, 1, 0);
        rt(32'h0302, 0, 8'h08, 8'h40, 7'd4, 1, 1);
        rt(32'h0302, 0, 8'h08, 8'h00, 7'd1, 0, 0);
        rt(32'h030a, 0, 8'h08, 8'h00, 7'd1, 1, 0);
        $display("test transmit done");
    endtask : t_tx
    // Only the sources marked live in standby may reach the pins
    task automatic t_standby;
        @(posedge pclk);
        stb <= 1;
        rt(32'h0301, 1, 8'ha0, 8'h20, 7'd1, 1, 0);
        rt(32'h0301, 1, 8'hf0, 8'h01, 7'd4, 0, 1);
        rt(32'h0302, 0, 8'h50, 8'h02, 7'd16, 0, 1);
        @(posedge pclk);
        stb <= 0;
        $display("test standby done");
    endtask : t_standby
    task automatic t_status;
        loadq(7'd0);
        apb(1, SEL, 32'h06);
        apb(0, SEL, 32'h0);
        chk("status empty", 32'h00, rd);
        loadq(7'd16);
        apb(0, SEL, 32'h0);
        chk("status full", 32'h06, rd);
        @(posedge pclk);
        ovr <= 1;
        @(posedge pclk);
        ovr <= 0;
        apb(1, SEL, 32'h00);
        apb(0, SEL, 32'h0);
        chk("overrun kept", 32'h07, rd);
        chk("queue kept", 32'd16, {25'h0, lvl});
        apb(1, SEL, 32'h01);
        repeat (3) @(posedge pclk);
        apb(0, SEL, 32'h0);
        chk("overrun cleared", 32'h00, rd);
        chk("queue flushed", 32'd0, {25'h0, lvl});
        apb(1, SEL, 32'ha8);
        apb(0, SEL, 32'h0);
        chk("selectors", 32'ha8, rd);
        $display("test status done");
    endtask : t_status
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_reset();
        t_cont();
        t_buf_rx();
        t_pkt_rx();
        t_tx();
        t_standby();
        t_status();
        tally_and_finish();
    end
endmodule : testbench
